/* File: common/tcc_defines.svh */
// Offsets, field positions, reset values and timing counts of the trace capture control
`ifndef TCC_DEFINES_SVH
`define TCC_DEFINES_SVH
`define TCC_AW              8
`define TCC_OFF_CTRL        8'h00
`define TCC_OFF_STAT        8'h04
`define TCC_OFF_LINES       8'h08
`define TCC_OFF_SEQ         8'h0c
`define TCC_OFF_A2T         8'h10
`define TCC_OFF_TADDR       8'h14
`define TCC_OFF_TMASK       8'h18
`define TCC_OFF_SADDR       8'h1c
`define TCC_OFF_SMASK       8'h20
`define TCC_OFF_OCC         8'h24
`define TCC_OFF_INDEX       8'h28
`define TCC_OFF_MADDR       8'h2c
`define TCC_OFF_MDATA       8'h30
`define TCC_OFF_MINFO       8'h34
`define TCC_OFF_ISTAT       8'h38
`define TCC_OFF_IMASK       8'h3c
`define TCC_CTRL_START      0
`define TCC_CTRL_HALT       1
`define TCC_CTRL_ARM_LSB    2
`define TCC_CTRL_QUAL_LSB   4
`define TCC_QUAL_FG         0
`define TCC_QUAL_BG         1
`define TCC_ARM_RESET       2'h0
`define TCC_QUAL_RESET      2'h1
`define TCC_MASK_RESET      32'h0
`define TCC_OCC_RESET       16'h0001
`define TCC_IRQ_TRIG        0
`define TCC_IRQ_DONE        1
`define TCC_IRQ_HALT        2
`define TCC_IRQ_ARM         3
`define TCC_IRQ_W           4
`define TCC_CLK_PERIOD_NS   10
`define TCC_A2T_MIN_NS      40
`define TCC_A2T_MAX_NS      41943000
`define TCC_A2T_MIN_CYC     ((`TCC_A2T_MIN_NS + `TCC_CLK_PERIOD_NS - 1) / `TCC_CLK_PERIOD_NS)
`define TCC_A2T_MAX_CYC     (`TCC_A2T_MAX_NS / `TCC_CLK_PERIOD_NS)
`endif

/* File: common/tcc_pkg.sv */
// Types shared by the trace capture control modules
`default_nettype none
`include "tcc_defines.svh"
package tcc_pkg;
  typedef struct packed {
    logic [31:0] addr;
    logic [15:0] data;
    logic [7:0]  stat;
  } tcc_sample_type;
  typedef struct packed {
    tcc_sample_type smp;
    logic [15:0]    tcount;
    logic           branch;
  } tcc_entry_type;
  typedef struct packed {
    logic                wr;
    logic                rd;
    logic [`TCC_AW-1:0]  addr;
    logic [31:0]         wdata;
  } tcc_req_type;
  typedef enum logic [4:0] {
    TCC_IDLE  = 5'b00001,
    TCC_WAIT  = 5'b00010,
    TCC_STORE = 5'b00100,
    TCC_DONE  = 5'b01000,
    TCC_HALT  = 5'b10000
  } tcc_mode_type;
endpackage
`default_nettype wire

/* File: logic/tcc_trace_mem.sv */
// Trace memory: one write port, one registered read port
`default_nettype none
module tcc_trace_mem
  import tcc_pkg::*;
#(
  parameter int DEPTH = 512,
  localparam int AW   = $clog2(DEPTH)
) (
  input  wire logic           clk,
  input  wire logic           rst,
  input  wire logic           we,
  input  wire logic [AW-1:0]  waddr,
  input  wire tcc_pkg::tcc_entry_type wentry,
  input  wire logic [AW-1:0]  raddr,
  output tcc_pkg::tcc_entry_type rentry
);
  tcc_entry_type mem [DEPTH];

  // Array has no reset; only the read register is cleared
  always_ff @(posedge clk)
  begin
    if (we)
      mem[waddr] <= wentry;
    if (rst)
      rentry <= '0;
    else
      rentry <= mem[raddr];
  end
endmodule
`default_nettype wire

/* File: logic/tcc_seq.sv */
// Trigger sequencer with one occurrence counter per term
`default_nettype none
`include "tcc_defines.svh"
module tcc_seq
  import tcc_pkg::*;
#(
  parameter int TERMS = 1,
  parameter int OCC_W = 16,
  localparam int TW   = $clog2(TERMS + 2)
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             restart,
  input  wire logic             hit,
  input  wire logic [OCC_W-1:0] occ_load,
  output logic      [TW-1:0]    term,
  output logic      [OCC_W-1:0] occ_left,
  output logic                  branch,
  output logic                  trig
);
  typedef struct packed {
    logic [TW-1:0]                term;
    logic [TERMS-1:0][OCC_W-1:0] occ;
  } tcc_seq_state_type;
  tcc_seq_state_type s_q, s_d;
  logic [TW-1:0] last;
  logic [TW-1:0] cur;

  if (TERMS < 1)
    $error("tcc_seq needs at least one term");

  // Terms count from one, so the index after the trigger is TERMS + 1
  assign last = TW'(TERMS);
  assign cur  = s_q.term - TW'(1);

  // Count matches down in the current term, branch when the count runs out
  always_comb
  begin
    s_d    = s_q;
    branch = 1'b0;
    trig   = 1'b0;
    if (restart)
    begin
      s_d.term = TW'(1);
      for (int i = 0; i < TERMS; i++)
        s_d.occ[i] = occ_load;
    end
    else if (hit && s_q.term <= last)
    begin
      if (s_q.occ[cur] <= OCC_W'(1))
      begin
        branch             = 1'b1;
        s_d.occ[cur]       = occ_load;
        s_d.term           = s_q.term + TW'(1);
        trig               = (s_q.term == last);
      end
      else
        s_d.occ[cur] = s_q.occ[cur] - OCC_W'(1);
    end
  end

  // After the trigger the term index points one past the last term
  assign term     = s_q.term;
  assign occ_left = (s_q.term > last) ? s_q.occ[TERMS-1] : s_q.occ[cur];

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s_q.term <= TW'(1);
      for (int i = 0; i < TERMS; i++)
        s_q.occ[i] <= OCC_W'(`TCC_OCC_RESET);
    end
    else
      s_q <= s_d;
  end
endmodule
`default_nettype wire

/* File: logic/tcc_top.sv */
// Trace capture control: trigger, storage, arm timing and status of a bus-state analyzer
//
// Chosen here: the address map and the plain strobed port.
`default_nettype none
`include "tcc_defines.svh"
module tcc_top
  import tcc_pkg::*;
#(
  parameter int DEPTH       = 512,
  parameter int TERMS       = 1,
  parameter int OCC_W       = 16,
  parameter int A2T_MAX_CYC = `TCC_A2T_MAX_CYC,
  localparam int AW         = $clog2(DEPTH),
  localparam int CW         = $clog2(DEPTH + 1),
  localparam int TW         = $clog2(TERMS + 2)
) (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire tcc_pkg::tcc_req_type   req,
  output logic [31:0]                 rdata,
  input  wire logic                   smp_valid,
  input  wire logic                   smp_bg,
  input  wire tcc_pkg::tcc_sample_type smp,
  input  wire logic                   cross_module_execute,
  input  wire logic [2:0]             arm_sig,
  output logic                        irq
);
  import tcc_pkg::*;

  localparam int MINC = `TCC_A2T_MIN_CYC;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
    $error("tcc_top DEPTH must be a power of two of at least 2");
  if (A2T_MAX_CYC < 1 || A2T_MAX_CYC >= (1 << 23))
    $error("tcc_top A2T_MAX_CYC out of counter range");
  if (MINC >= 7 || OCC_W > 16 || TW > 8)
    $error("tcc_top field widths exceeded");

  typedef struct packed {
    tcc_mode_type         mode;
    logic [1:0]           arm_sel;
    logic [1:0]           qual;
    logic [31:0]          taddr;
    logic [31:0]          tmask;
    logic [31:0]          saddr;
    logic [31:0]          smask;
    logic [OCC_W-1:0]     occ;
    logic [AW-1:0]        index;
    logic [CW-1:0]        wptr;
    logic [15:0]          tcount;
    logic                 newf;
    logic                 cmb_src;
    logic                 started;
    logic                 arm_rcvd;
    logic                 trig_seen;
    logic                 a2t_done;
    logic                 a2t_under;
    logic                 a2t_over;
    logic [23:0]          a_cnt;
    logic [2:0]           p_cnt;
    logic [23:0]          a2t_val;
    logic                 chg;
    logic [`TCC_IRQ_W-1:0] istat;
    logic [`TCC_IRQ_W-1:0] imask;
    logic [31:0]          rdata;
  } tcc_top_state_type;

  tcc_top_state_type s_q, s_d;
  logic                  qual;
  logic                  trig_match;
  logic                  stor_match;
  logic                  wr_ctrl;
  logic                  start;
  logic                  halt;
  logic                  seq_hit;
  logic                  arm_ev;
  logic                  running;
  logic [TW-1:0]         term;
  logic [OCC_W-1:0]      occ_left;
  logic                  branch;
  logic                  seq_trig;
  logic                  we;
  logic [AW-1:0]         waddr;
  tcc_entry_type         wentry;
  tcc_entry_type         rentry;
  logic [`TCC_IRQ_W-1:0] ev;

  // Analyzer clock qualifier: foreground, background or both
  assign qual = smp_valid && (smp_bg ? s_q.qual[`TCC_QUAL_BG] : s_q.qual[`TCC_QUAL_FG]);
  // A zero mask compares no bits, so the reset pattern matches any state
  assign trig_match = ((smp.addr ^ s_q.taddr) & s_q.tmask) == 32'h0;
  assign stor_match = ((smp.addr ^ s_q.saddr) & s_q.smask) == 32'h0;
  assign running    = s_q.mode == TCC_WAIT || s_q.mode == TCC_STORE;

  // Start comes from the host or from the cross-module execute line; start beats halt
  assign wr_ctrl = req.wr && req.addr == `TCC_OFF_CTRL;
  assign start   = (wr_ctrl && req.wdata[`TCC_CTRL_START]) || cross_module_execute;
  assign halt    = wr_ctrl && req.wdata[`TCC_CTRL_HALT] && running && !start;
  assign seq_hit = qual && trig_match && s_q.mode == TCC_WAIT;
  assign arm_ev  = s_q.arm_sel != 2'h0 && arm_sig[s_q.arm_sel - 2'h1];

  tcc_seq #(
    .TERMS    (TERMS),
    .OCC_W    (OCC_W)
  ) u_seq (
    .clk      (clk),
    .rst      (rst),
    .restart  (start),
    .hit      (seq_hit),
    .occ_load (s_q.occ),
    .term     (term),
    .occ_left (occ_left),
    .branch   (branch),
    .trig     (seq_trig)
  );

  // Read address follows the next index so a read right after a write sees it
  tcc_trace_mem #(
    .DEPTH  (DEPTH)
  ) u_mem (
    .clk    (clk),
    .rst    (rst),
    .we     (we),
    .waddr  (waddr),
    .wentry (wentry),
    .raddr  (s_d.index),
    .rentry (rentry)
  );

  // Measurement sequence, arm timing, register file and read mux
  always_comb
  begin
    s_d    = s_q;
    ev     = '0;
    we     = 1'b0;
    waddr  = s_q.wptr[AW-1:0];
    wentry = '0;
    wentry.smp    = smp;
    wentry.tcount = s_q.tcount;
    // Relative time since the last stored state, saturating
    if (s_q.tcount != 16'hffff)
      s_d.tcount = s_q.tcount + 16'h1;

    case (s_q.mode)
      TCC_WAIT:
      begin
        if (seq_trig)
        begin
          we             = 1'b1;
          waddr          = '0;
          wentry.tcount  = 16'h0;
          wentry.branch  = branch;
          s_d.wptr       = CW'(1);
          s_d.tcount     = 16'h1;
          s_d.mode       = TCC_STORE;
          ev[`TCC_IRQ_TRIG] = 1'b1;
        end
      end
      TCC_STORE:
      begin
        if (qual && stor_match)
        begin
          we         = 1'b1;
          s_d.wptr   = s_q.wptr + CW'(1);
          s_d.tcount = 16'h1;
          if (s_q.wptr == CW'(DEPTH - 1))
          begin
            s_d.mode          = TCC_DONE;
            s_d.newf          = 1'b1;
            ev[`TCC_IRQ_DONE] = 1'b1;
          end
        end
      end
      default:
      begin
      end
    endcase

    // Halt freezes capture and the sequencer term with it
    if (halt)
    begin
      s_d.mode          = TCC_HALT;
      s_d.newf          = 1'b1;
      ev[`TCC_IRQ_HALT] = 1'b1;
    end

    // Arm is latched any time after a start, even once stopped
    if (s_q.started && arm_ev && !s_q.arm_rcvd)
    begin
      s_d.arm_rcvd     = 1'b1;
      s_d.a_cnt        = 24'h1;
      ev[`TCC_IRQ_ARM] = 1'b1;
    end
    // Time from arm to trigger, one more than the ceiling marks overflow
    if (s_q.arm_rcvd && !s_q.trig_seen && s_q.a_cnt <= 24'(A2T_MAX_CYC))
      s_d.a_cnt = s_q.a_cnt + 24'h1;
    if (seq_trig && s_q.mode == TCC_WAIT)
    begin
      s_d.trig_seen = 1'b1;
      s_d.p_cnt     = 3'h1;
      if (s_q.arm_rcvd || (s_q.started && arm_ev))
      begin
        s_d.a2t_done = 1'b1;
        s_d.a2t_val  = s_q.arm_rcvd ? s_q.a_cnt : 24'h0;
        s_d.a2t_over = s_q.arm_rcvd && s_q.a_cnt > 24'(A2T_MAX_CYC);
      end
    end
    else if (s_q.trig_seen && !s_q.a2t_done)
    begin
      // Arm after the trigger gives a negative interval, bounded below
      if (arm_ev)
      begin
        s_d.a2t_done  = 1'b1;
        s_d.a2t_val   = 24'h0 - 24'(s_q.p_cnt);
        s_d.a2t_under = s_q.p_cnt > 3'(MINC);
      end
      else if (s_q.p_cnt <= 3'(MINC))
        s_d.p_cnt = s_q.p_cnt + 3'h1;
    end

    // A new start clears the previous measurement's results
    if (start)
    begin
      s_d.mode      = TCC_WAIT;
      s_d.cmb_src   = !(wr_ctrl && req.wdata[`TCC_CTRL_START]);
      s_d.started   = 1'b1;
      s_d.wptr      = '0;
      s_d.arm_rcvd  = 1'b0;
      s_d.trig_seen = 1'b0;
      s_d.a2t_done  = 1'b0;
      s_d.a2t_under = 1'b0;
      s_d.a2t_over  = 1'b0;
      s_d.a_cnt     = '0;
      s_d.p_cnt     = '0;
    end

    s_d.chg = seq_hit || start;

    // Register writes; start and halt bits are strobes and are not kept
    if (req.wr)
    begin
      case (req.addr)
        `TCC_OFF_CTRL:
        begin
          s_d.arm_sel = req.wdata[`TCC_CTRL_ARM_LSB +: 2];
          s_d.qual    = req.wdata[`TCC_CTRL_QUAL_LSB +: 2];
        end
        `TCC_OFF_TADDR: s_d.taddr = req.wdata;
        `TCC_OFF_TMASK: s_d.tmask = req.wdata;
        `TCC_OFF_SADDR: s_d.saddr = req.wdata;
        `TCC_OFF_SMASK: s_d.smask = req.wdata;
        `TCC_OFF_OCC:   s_d.occ   = req.wdata[OCC_W-1:0];
        `TCC_OFF_INDEX: s_d.index = req.wdata[AW-1:0];
        `TCC_OFF_IMASK: s_d.imask = req.wdata[`TCC_IRQ_W-1:0];
        default:
        begin
        end
      endcase
    end
    // Sticky events: write one to clear, a new event in the same cycle wins
    if (req.wr && req.addr == `TCC_OFF_ISTAT)
      s_d.istat = s_q.istat & ~req.wdata[`TCC_IRQ_W-1:0];
    s_d.istat = s_d.istat | ev;

    // Read data stand only in the cycle after the strobe
    s_d.rdata = 32'h0;
    if (req.rd)
    begin
      case (req.addr)
        `TCC_OFF_CTRL:
        begin
          s_d.rdata[`TCC_CTRL_ARM_LSB +: 2]  = s_q.arm_sel;
          s_d.rdata[`TCC_CTRL_QUAL_LSB +: 2] = s_q.qual;
        end
        `TCC_OFF_STAT:
          s_d.rdata[7:0] = {s_q.trig_seen, s_q.arm_rcvd && s_q.arm_sel != 2'h0,
                            s_q.arm_sel == 2'h0, s_q.cmb_src, s_q.newf,
                            s_q.mode == TCC_HALT, s_q.mode == TCC_DONE, running};
        `TCC_OFF_LINES:
        begin
          s_d.rdata[CW-1:0]     = s_q.wptr;
          s_d.rdata[16 +: CW]   = CW'(DEPTH);
        end
        `TCC_OFF_SEQ:
        begin
          s_d.rdata[TW-1:0]       = term;
          s_d.rdata[8]            = seq_hit || s_q.chg;
          s_d.rdata[9]            = seq_hit || s_q.chg;
          s_d.rdata[16 +: OCC_W]  = occ_left;
        end
        `TCC_OFF_A2T:
          s_d.rdata[26:0] = {s_q.arm_sel == 2'h0 || !s_q.a2t_done,
                             s_q.a2t_over, s_q.a2t_under, s_q.a2t_val};
        `TCC_OFF_TADDR: s_d.rdata = s_q.taddr;
        `TCC_OFF_TMASK: s_d.rdata = s_q.tmask;
        `TCC_OFF_SADDR: s_d.rdata = s_q.saddr;
        `TCC_OFF_SMASK: s_d.rdata = s_q.smask;
        `TCC_OFF_OCC:   s_d.rdata[OCC_W-1:0] = s_q.occ;
        `TCC_OFF_INDEX: s_d.rdata[AW-1:0]    = s_q.index;
        `TCC_OFF_MADDR: s_d.rdata = rentry.smp.addr;
        `TCC_OFF_MDATA: s_d.rdata[23:0] = {rentry.smp.stat, rentry.smp.data};
        `TCC_OFF_MINFO:
        begin
          s_d.rdata[16:0] = {rentry.branch, rentry.tcount};
          s_d.newf        = 1'b0;
        end
        `TCC_OFF_ISTAT: s_d.rdata[`TCC_IRQ_W-1:0] = s_q.istat;
        `TCC_OFF_IMASK: s_d.rdata[`TCC_IRQ_W-1:0] = s_q.imask;
        default:        s_d.rdata = 32'h0;
      endcase
    end
    // A measurement ending while its flag is being read keeps the flag
    if ((s_q.mode == TCC_STORE && s_d.mode == TCC_DONE) || halt)
      s_d.newf = 1'b1;
  end

  assign rdata = s_q.rdata;
  assign irq   = |(s_q.istat & s_q.imask);

  // Single state register; masks reset to zero so any state triggers and stores
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s_q         <= '0;
      s_q.mode    <= TCC_IDLE;
      s_q.arm_sel <= `TCC_ARM_RESET;
      s_q.qual    <= `TCC_QUAL_RESET;
      s_q.tmask   <= `TCC_MASK_RESET;
      s_q.smask   <= `TCC_MASK_RESET;
      s_q.occ     <= OCC_W'(`TCC_OCC_RESET);
    end
    else
      s_q <= s_d;
  end
endmodule
`default_nettype wire

/* File: verification/tcc_top_assertions.sv */
// Port-level assertions of the trace capture control
`default_nettype none
`include "tcc_defines.svh"
module tcc_top_check
#(
  parameter int DEPTH = 512,
  parameter int TERMS = 1
) (
  input wire logic                    clk,
  input wire logic                    rst,
  input wire tcc_pkg::tcc_req_type    req,
  input wire logic [31:0]             rdata,
  input wire logic                    smp_valid,
  input wire logic                    smp_bg,
  input wire tcc_pkg::tcc_sample_type smp,
  input wire logic                    cross_module_execute,
  input wire logic [2:0]              arm_sig,
  input wire logic                    irq
);
  import tcc_pkg::*;
  logic       rd_q;
  logic [7:0] ra_q;
  logic [3:0] cf_q;
  logic [3:0] cf_rd_q;
  logic       st_rd;
  // Last read and control fields; the read-time copy avoids a write racing the answer
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rd_q    <= 1'b0;
      ra_q    <= 8'h00;
      cf_q    <= 4'h4;
      cf_rd_q <= 4'h4;
    end
    else
    begin
      rd_q    <= req.rd;
      ra_q    <= req.addr;
      cf_rd_q <= req.rd ? cf_q : cf_rd_q;
      cf_q    <= (req.wr && req.addr == `TCC_OFF_CTRL) ? req.wdata[5:2] : cf_q;
    end
  end
  // Status answer stands now
  assign st_rd = rd_q && ra_q == `TCC_OFF_STAT;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  a_rdata_quiet: assert property (!rd_q |-> rdata == 32'h0)
    else $error("read data outside its cycle");
  a_reset_quiet: assert property ($past(rst) |-> !irq && rdata == 32'h0)
    else $error("outputs active right after reset");
  a_mode_single: assert property (st_rd |-> $countones(rdata[2:0]) <= 1)
    else $error("more than one measurement status");
  a_done_trig: assert property (st_rd && rdata[1] |-> rdata[7])
    else $error("complete without trigger in memory");
  a_arm_ignored: assert property (st_rd |-> rdata[5] == (cf_rd_q[1:0] == 2'h0))
    else $error("arm ignored flag wrong");
  a_a2t_unknown: assert property (rd_q && ra_q == `TCC_OFF_A2T && cf_rd_q[1:0] == 2'h0
    |-> rdata[26])
    else $error("arm to trigger known while arm ignored");
  a_lines_cap: assert property (rd_q && ra_q == `TCC_OFF_LINES
    |-> rdata[25:16] == 10'(DEPTH) && rdata[9:0] <= 10'(DEPTH))
    else $error("stored state count out of range");
  a_ctrl_fields: assert property (rd_q && ra_q == `TCC_OFF_CTRL
    |-> rdata[5:2] == cf_rd_q)
    else $error("control fields read back wrong");
  a_term_range: assert property (rd_q && ra_q == `TCC_OFF_SEQ
    |-> rdata[7:0] != 8'h0 && rdata[7:0] <= 8'(TERMS + 1))
    else $error("sequencer term beyond range");
  c_complete: cover property (st_rd && rdata[1]);
  c_halted: cover property (st_rd && rdata[2]);
  c_cross_start: cover property (st_rd && rdata[4]);
endmodule
bind tcc_top tcc_top_check #(.DEPTH(DEPTH), .TERMS(TERMS)) chk_u (.clk(clk), .rst(rst),
  .req(req), .rdata(rdata), .smp_valid(smp_valid), .smp_bg(smp_bg), .smp(smp),
  .cross_module_execute(cross_module_execute), .arm_sig(arm_sig), .irq(irq));
`default_nettype wire

/* File: verification/tcc_bus_model.sv */
// Behavioural model of the emulated processor bus feeding analyzer states
`default_nettype none
module tcc_bus_model
(
  input  wire logic                    clk,
  input  wire logic                    run,
  input  wire logic                    slow,
  input  wire logic                    bg,
  input  wire logic [31:0]             base,
  output var  logic                    smp_valid,
  output var  logic                    smp_bg,
  output var  tcc_pkg::tcc_sample_type smp
);
  timeunit 1ns;
  timeprecision 1ps;
  import tcc_pkg::*;
  logic [15:0] n   = 16'h0;
  logic        tck = 1'b0;
  initial smp_valid = 1'b0;
  initial smp_bg = 1'b0;
  initial smp = '0;
  // One bus cycle per clock, or every other clock when slow
  always @(posedge clk)
  begin
    tck <= ~tck;
    if (run && (!slow || tck))
    begin
      n         <= n + 16'h1;
      smp_valid <= 1'b1;
      smp_bg    <= bg;
      smp.addr  <= base + {15'h0, n, 1'b0};
      smp.data  <= n ^ 16'ha5a5;
      smp.stat  <= n[7:0];
    end
    else
    begin
      n         <= run ? n : 16'h0;
      smp_valid <= 1'b0;
      smp_bg    <= ~smp_bg;
      smp       <= ~smp; // Idle bus must not look like the last state
    end
  end
endmodule
`default_nettype wire

/* File: verification/tcc_top_bench.sv */
// Self-checking bench of the trace capture control
`default_nettype none
`include "tcc_defines.svh"
module tcc_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import tcc_pkg::*;
  localparam int A2T = 50;
  typedef struct packed {logic [31:0] m; logic [31:0] v;} tcc_note_type;
  logic           clk  = 1'b0;
  logic           rst  = 1'b1;
  tcc_req_type    req  = '0;
  logic           cme  = 1'b0;
  logic [2:0]     arm  = 3'h0;
  logic           run  = 1'b0;
  logic           slow = 1'b0;
  logic           bg   = 1'b0;
  logic [31:0]    base = 32'h0;
  logic [31:0]    rdata;
  logic           smp_valid;
  logic           smp_bg;
  tcc_sample_type smp;
  logic           irq;
  logic           rd_seen = 1'b0;
  int             error_cnt = 0;
  int             num_checks = 0;
  tcc_note_type   notes[$];
  tcc_top #(.A2T_MAX_CYC(A2T)) dut_u (.clk(clk), .rst(rst), .req(req), .rdata(rdata),
    .smp_valid(smp_valid), .smp_bg(smp_bg), .smp(smp), .cross_module_execute(cme),
    .arm_sig(arm), .irq(irq));
  tcc_bus_model bus_u (.clk(clk), .run(run), .slow(slow), .bg(bg), .base(base),
    .smp_valid(smp_valid), .smp_bg(smp_bg), .smp(smp));
  initial forever #5 clk = ~clk;
  task automatic stop_test();
    if (error_cnt == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One strobe cycle, then the bus falls idle
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clk);
    req <= '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
    notes.push_back('{m: m, v: v});
    bus(1'b0, a, 32'h0);
  endtask
  task automatic wait_irq(input int lim);
    for (int i = 0; i < lim && irq !== 1'b1; i++)
      @(posedge clk);
    if (irq !== 1'b1)
    begin
      error_cnt++;
      stop_test();
    end
  endtask
  task automatic irq_is(input logic e);
    @(posedge clk);
    check({31'h0, irq}, {31'h0, e});
  endtask
  // Read answers stand one cycle after the strobe; compare with the oldest note
  always @(posedge clk)
  begin
    if (rd_seen)
    begin
      if (notes.size() == 0)
        check(rdata, 32'hdead_beef);
      else
        check(rdata & notes[0].m, notes[0].v);
      if (notes.size() != 0)
        void'(notes.pop_front());
    end
    rd_seen <= req.rd;
  end
  initial
  begin
    int k;
    void'($urandom(32'hd01f4363));
    base = $urandom() & 32'hffff_fff0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    // Reset values, unmapped place
    rd(`TCC_OFF_CTRL, 32'h3c, 32'h10);
    rd(`TCC_OFF_STAT, 32'h7, 32'h0);
    rd(8'hfc, 32'hffff_ffff, 32'h0);
    rd(`TCC_OFF_LINES, 32'h03ff_03ff, 32'h0200_0000);
    // Host start, any-state trigger, fill all lines
    bus(1'b1, `TCC_OFF_IMASK, 32'h2);
    bus(1'b1, `TCC_OFF_CTRL, 32'h11);
    run <= 1'b1;
    rd(`TCC_OFF_STAT, 32'h7, 32'h1);
    wait_irq(700);
    run <= 1'b0;
    rd(`TCC_OFF_STAT, 32'hbf, 32'haa);
    rd(`TCC_OFF_LINES, 32'h03ff_03ff, 32'h0200_0200);
    rd(`TCC_OFF_SEQ, 32'hffff_03ff, 32'h0001_0002);
    rd(`TCC_OFF_A2T, 32'h0400_0000, 32'h0400_0000);
    for (int i = 0; i < 4; i++)
    begin
      k = (i == 0) ? 0 : (i == 1) ? 511 : $urandom_range(510, 1);
      bus(1'b1, `TCC_OFF_INDEX, 32'(k));
      rd(`TCC_OFF_MADDR, 32'hffff_ffff, base + 32'(2 * k));
      rd(`TCC_OFF_MDATA, 32'h00ff_ffff, {8'h0, 8'(k), 16'(k) ^ 16'ha5a5});
      rd(`TCC_OFF_MINFO, 32'h1_ffff, (k == 0) ? 32'h1_0000 : 32'h1);
    end
    rd(`TCC_OFF_STAT, 32'h8, 32'h0);
    bus(1'b1, `TCC_OFF_ISTAT, 32'hf);
    irq_is(1'b0);
    // Background-only qualifier sees no state; halt keeps term 1
    bus(1'b1, `TCC_OFF_CTRL, 32'h21);
    run <= 1'b1;
    repeat (20) @(posedge clk);
    bus(1'b1, `TCC_OFF_CTRL, 32'h22);
    run <= 1'b0;
    rd(`TCC_OFF_STAT, 32'h8f, 32'h0c);
    rd(`TCC_OFF_LINES, 32'h3ff, 32'h0);
    rd(`TCC_OFF_SEQ, 32'hff, 32'h1);
    irq_is(1'b0);
    bus(1'b1, `TCC_OFF_IMASK, 32'hf);
    irq_is(1'b1);
    bus(1'b1, `TCC_OFF_ISTAT, 32'hf);
    bus(1'b1, `TCC_OFF_IMASK, 32'h2);
    irq_is(1'b0);
    // Cross-module start, early arm, slow background states, overflow
    bus(1'b1, `TCC_OFF_CTRL, 32'h34);
    cme <= 1'b1;
    @(posedge clk);
    cme <= 1'b0;
    arm <= 3'h1;
    repeat (A2T + 10) @(posedge clk);
    slow <= 1'b1;
    bg <= 1'b1;
    run <= 1'b1;
    wait_irq(1500);
    run <= 1'b0;
    arm <= 3'h0;
    rd(`TCC_OFF_STAT, 32'hff, 32'hda);
    rd(`TCC_OFF_A2T, 32'h0700_0000, 32'h0200_0000);
    bus(1'b1, `TCC_OFF_INDEX, 32'h3);
    rd(`TCC_OFF_MINFO, 32'h1_ffff, 32'h2);
    // Three occurrences per term, halt after trigger, arm after halt
    bus(1'b1, `TCC_OFF_ISTAT, 32'hf);
    bus(1'b1, `TCC_OFF_OCC, 32'h3);
    slow <= 1'b0;
    bg <= 1'b0;
    bus(1'b1, `TCC_OFF_CTRL, 32'h19);
    run <= 1'b1;
    // Read lands on the first hit: term and count are moving
    rd(`TCC_OFF_SEQ, 32'hffff_03ff, 32'h0003_0301);
    repeat (30) @(posedge clk);
    bus(1'b1, `TCC_OFF_CTRL, 32'h1a);
    run <= 1'b0;
    repeat (10) @(posedge clk);
    arm <= 3'h2;
    repeat (3) @(posedge clk);
    rd(`TCC_OFF_STAT, 32'hff, 32'hcc);
    rd(`TCC_OFF_SEQ, 32'hff, 32'h2);
    rd(`TCC_OFF_A2T, 32'h0700_0000, 32'h0100_0000);
    bus(1'b1, `TCC_OFF_INDEX, 32'h0);
    rd(`TCC_OFF_MADDR, 32'hffff_ffff, base + 32'h4);
    repeat (3) @(posedge clk);
    stop_test();
  end
endmodule
`default_nettype wire
